// ---- cbr_defs.vh ----
`ifndef CBR_DEFS_VH
`define CBR_DEFS_VH

// ----------------------------------------
// operand selector codes, core port and bus
// ----------------------------------------
`define CBR_SEL_R0   5'h00
`define CBR_SEL_R1   5'h01
`define CBR_SEL_R2   5'h02
`define CBR_SEL_R3   5'h03
`define CBR_SEL_A0   5'h04
`define CBR_SEL_A1   5'h05
`define CBR_SEL_FB   5'h06
`define CBR_SEL_VECTOR_TABLE_BASE 5'h07
`define CBR_SEL_IP   5'h08
`define CBR_SEL_USP  5'h09
`define CBR_SEL_ISP  5'h0a
`define CBR_SEL_SB   5'h0b
`define CBR_SEL_FLG  5'h0c
`define CBR_SEL_R0L  5'h0d
`define CBR_SEL_R0H  5'h0e
`define CBR_SEL_R1L  5'h0f
`define CBR_SEL_R1H  5'h10
`define CBR_SEL_LONG_DATA_PAIR_LOW 5'h11
`define CBR_SEL_LONG_DATA_PAIR_HIGH 5'h12
`define CBR_SEL_LONG_ADDRESS_PAIR 5'h13
`define CBR_SEL_SP   5'h14
`define CBR_SEL_LAST 6'h14

// ----------------------------------------
// banked storage layout
// ----------------------------------------
`define CBR_BANKED   14
`define CBR_PER_BANK 7
`define CBR_RW       16

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define CBR_FLG_C    0
`define CBR_FLG_D    1
`define CBR_FLG_Z    2
`define CBR_FLG_S    3
`define CBR_FLG_B    4
`define CBR_FLG_O    5
`define CBR_FLG_I    6
`define CBR_FLG_U    7

// ----------------------------------------
// reset values, sizes, constants
// ----------------------------------------
`define CBR_RST16    16'h0000
`define CBR_RST20    20'h0_0000
`define CBR_FLG_RST  11'h000
`define CBR_SZ_BYTE  2'h0
`define CBR_SZ_WORD  2'h1
`define CBR_BE_ALL   4'hf
`define CBR_BE_NONE  4'h0
`define CBR_ZERO32   32'h0000_0000

`endif

// ---- cbr_regfile.v ----
`timescale 1ns/1ps
`include "cbr_defs.vh"

module cbr_regfile (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire        wb_ack_out,
  input  wire        wr_en_in,
  input  wire [4:0]  wr_sel_in,
  input  wire [31:0] wr_data_in,
  input  wire [4:0]  rd_sel_in,
  output wire [31:0] rd_data_out,
  input  wire        ip_we_in,
  input  wire [19:0] ip_next_in,
  input  wire        alu_c_we_in,
  input  wire        alu_carry_in,
  input  wire        alu_zs_we_in,
  input  wire [1:0]  alu_size_in,
  input  wire [31:0] alu_result_in,
  input  wire        alu_o_we_in,
  input  wire        alu_ovf_in,
  output wire [15:0] address_register_0_out,
  output wire [15:0] address_register_1_out,
  output wire [15:0] frame_base_out,
  output wire [15:0] static_base_out,
  output wire [19:0] vector_table_base_out,
  output wire [19:0] instruction_pointer_out,
  output wire [15:0] stack_pointer_out,
  output wire [10:0] processor_flags_out
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg  [15:0]  bank_q [0:`CBR_BANKED-1];
  reg  [19:0]  vtb;
  reg  [19:0]  ip;
  reg  [15:0]  user_stack_pointer;
  reg  [15:0]  interrupt_stack_pointer;
  reg  [15:0]  sbr;
  reg  [10:0]  processor_flags;
  reg          wb_ack;
  reg  [31:0]  wb_dat;
  reg  [31:0]  rd_data;
  reg  [10:0]  flg_alu;
  reg          res_zero;
  reg          res_sign;
  integer      n;

  wire [16*`CBR_BANKED-1:0]   nxt;
  wire [16*`CBR_PER_BANK-1:0] cur;
  wire         bk = processor_flags[`CBR_FLG_B];
  wire         stk = processor_flags[`CBR_FLG_U];

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function [31:0] cbr_merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  be;
    integer i;
    begin
      cbr_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i])
          cbr_merge[i*8 +: 8] = val[i*8 +: 8];
      end
    end
  endfunction

  // byte lanes of banked slot r hit by selector s
  function [1:0] cbr_mask;
    input [4:0] s;
    input [2:0] r;
    input [3:0] be;
    begin
      cbr_mask = 2'h0;
      if (s == {2'h0, r})
        cbr_mask = be[1:0];
      if ((s == `CBR_SEL_R0L && r == 3'h0) ||
          (s == `CBR_SEL_R1L && r == 3'h1))
        cbr_mask = {1'b0, be[0]};
      if ((s == `CBR_SEL_R0H && r == 3'h0) ||
          (s == `CBR_SEL_R1H && r == 3'h1))
        cbr_mask = {be[0], 1'b0};
      if ((s == `CBR_SEL_LONG_DATA_PAIR_LOW && r == 3'h0) ||
          (s == `CBR_SEL_LONG_DATA_PAIR_HIGH && r == 3'h1) ||
          (s == `CBR_SEL_LONG_ADDRESS_PAIR && r == 3'h4))
        cbr_mask = be[1:0];
      if ((s == `CBR_SEL_LONG_DATA_PAIR_LOW && r == 3'h2) ||
          (s == `CBR_SEL_LONG_DATA_PAIR_HIGH && r == 3'h3) ||
          (s == `CBR_SEL_LONG_ADDRESS_PAIR && r == 3'h5))
        cbr_mask = be[3:2];
    end
  endfunction

  // data for banked slot r under selector s
  function [15:0] cbr_val;
    input [4:0]  s;
    input [2:0]  r;
    input [31:0] d;
    begin
      if ((s == `CBR_SEL_LONG_DATA_PAIR_LOW && r == 3'h2) ||
          (s == `CBR_SEL_LONG_DATA_PAIR_HIGH && r == 3'h3) ||
          (s == `CBR_SEL_LONG_ADDRESS_PAIR && r == 3'h5))
        cbr_val = d[31:16];
      else if (s >= `CBR_SEL_R0L && s <= `CBR_SEL_R1H)
        cbr_val = {d[7:0], d[7:0]};
      else
        cbr_val = d[15:0];
    end
  endfunction

  // ----------------------------------------
  // wishbone slave, one wait state
  // ----------------------------------------
  wire [5:0] bus_idx = wb_adr_in[7:2];
  wire       bus_hit = (bus_idx <= `CBR_SEL_LAST);
  wire [4:0] bus_sel = bus_idx[4:0];
  // ack masks the request so a held strobe is not taken twice
  wire       bus_req = wb_cyc_in & wb_stb_in & ~wb_ack;
  // write commits on the acked edge, when master samples ack
  wire       bus_wr  = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack & bus_hit;

  // ----------------------------------------
  // banked registers
  // ----------------------------------------
  genvar k;
  generate
    for (k = 0; k < `CBR_BANKED; k = k + 1) begin : g_bank
      localparam       BNK = (k >= `CBR_PER_BANK);
      // slot within its bank, cut to three bits on purpose
      localparam integer SLI = k % `CBR_PER_BANK;
      localparam [2:0] SLT = SLI[2:0];
      // only the copy in the selected bank sees writes
      wire [1:0] cm = (bk == BNK && wr_en_in) ?
                      cbr_mask(wr_sel_in, SLT, `CBR_BE_ALL) : 2'h0;
      wire [1:0] bm = (bk == BNK && bus_wr) ?
                      cbr_mask(bus_sel, SLT, wb_sel_in) : 2'h0;
      wire [31:0] mc = cbr_merge({16'h0000, bank_q[k]},
                                 {16'h0000, cbr_val(wr_sel_in, SLT, wr_data_in)},
                                 {2'h0, cm});
      wire [31:0] mb = cbr_merge(mc,
                                 {16'h0000, cbr_val(bus_sel, SLT, wb_dat_in)},
                                 {2'h0, bm});
      assign nxt[k*16 +: 16] = mb[15:0];
      if (k < `CBR_PER_BANK) begin : g_cur
        assign cur[k*16 +: 16] = bk ? bank_q[k+`CBR_PER_BANK] : bank_q[k];
      end
    end
  endgenerate

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (n = 0; n < `CBR_BANKED; n = n + 1)
        bank_q[n] <= `CBR_RST16;
    end else begin
      for (n = 0; n < `CBR_BANKED; n = n + 1)
        bank_q[n] <= nxt[n*16 +: 16];
    end
  end

  // ----------------------------------------
  // active bank view
  // ----------------------------------------
  wire [15:0] act_r0 = cur[`CBR_SEL_R0*`CBR_RW +: `CBR_RW];
  wire [15:0] act_r1 = cur[`CBR_SEL_R1*`CBR_RW +: `CBR_RW];
  wire [15:0] act_r2 = cur[`CBR_SEL_R2*`CBR_RW +: `CBR_RW];
  wire [15:0] act_r3 = cur[`CBR_SEL_R3*`CBR_RW +: `CBR_RW];
  wire [15:0] act_a0 = cur[`CBR_SEL_A0*`CBR_RW +: `CBR_RW];
  wire [15:0] act_a1 = cur[`CBR_SEL_A1*`CBR_RW +: `CBR_RW];
  wire [15:0] act_fb = cur[`CBR_SEL_FB*`CBR_RW +: `CBR_RW];
  wire [15:0] sp_act = stk ? interrupt_stack_pointer : user_stack_pointer;

  // ----------------------------------------
  // read view shared by core and bus
  // ----------------------------------------
  function [31:0] cbr_view;
    input [4:0] s;
    begin
      case (s)
        `CBR_SEL_R0:   cbr_view = {16'h0000, act_r0};
        `CBR_SEL_R1:   cbr_view = {16'h0000, act_r1};
        `CBR_SEL_R2:   cbr_view = {16'h0000, act_r2};
        `CBR_SEL_R3:   cbr_view = {16'h0000, act_r3};
        `CBR_SEL_A0:   cbr_view = {16'h0000, act_a0};
        `CBR_SEL_A1:   cbr_view = {16'h0000, act_a1};
        `CBR_SEL_FB:   cbr_view = {16'h0000, act_fb};
        `CBR_SEL_VECTOR_TABLE_BASE: cbr_view = {12'h000, vtb};
        `CBR_SEL_IP:   cbr_view = {12'h000, ip};
        `CBR_SEL_USP:  cbr_view = {16'h0000, user_stack_pointer};
        `CBR_SEL_ISP:  cbr_view = {16'h0000, interrupt_stack_pointer};
        `CBR_SEL_SB:   cbr_view = {16'h0000, sbr};
        `CBR_SEL_FLG:  cbr_view = {21'h00_0000, processor_flags};
        `CBR_SEL_R0L:  cbr_view = {24'h00_0000, act_r0[7:0]};
        `CBR_SEL_R0H:  cbr_view = {24'h00_0000, act_r0[15:8]};
        `CBR_SEL_R1L:  cbr_view = {24'h00_0000, act_r1[7:0]};
        `CBR_SEL_R1H:  cbr_view = {24'h00_0000, act_r1[15:8]};
        `CBR_SEL_LONG_DATA_PAIR_LOW: cbr_view = {act_r2, act_r0};
        `CBR_SEL_LONG_DATA_PAIR_HIGH: cbr_view = {act_r3, act_r1};
        `CBR_SEL_LONG_ADDRESS_PAIR: cbr_view = {act_a1, act_a0};
        `CBR_SEL_SP:   cbr_view = {16'h0000, sp_act};
        default:       cbr_view = `CBR_ZERO32;
      endcase
    end
  endfunction

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_ack  <= 1'b0;
      wb_dat  <= `CBR_ZERO32;
      rd_data <= `CBR_ZERO32;
    end else begin
      wb_ack  <= bus_req;
      // unmapped index reads zero, ack still given
      if (bus_req)
        wb_dat <= bus_hit ? cbr_view(bus_sel) : `CBR_ZERO32;
      rd_data <= cbr_view(rd_sel_in);
    end
  end

  // ----------------------------------------
  // unbanked registers
  // ----------------------------------------
  function [31:0] cbr_upd;
    input [31:0] old;
    input        ch;
    input        bh;
    begin
      cbr_upd = cbr_merge(cbr_merge(old, wr_data_in, ch ? `CBR_BE_ALL : `CBR_BE_NONE),
                          wb_dat_in, bh ? wb_sel_in : `CBR_BE_NONE);
    end
  endfunction

  wire c_sel_usp = (wr_sel_in == `CBR_SEL_USP) || (wr_sel_in == `CBR_SEL_SP && !stk);
  wire c_sel_isp = (wr_sel_in == `CBR_SEL_ISP) || (wr_sel_in == `CBR_SEL_SP && stk);
  wire b_sel_usp = (bus_sel == `CBR_SEL_USP) || (bus_sel == `CBR_SEL_SP && !stk);
  wire b_sel_isp = (bus_sel == `CBR_SEL_ISP) || (bus_sel == `CBR_SEL_SP && stk);

  wire [31:0] vtb_n = cbr_upd({12'h000, vtb},
                              wr_en_in && wr_sel_in == `CBR_SEL_VECTOR_TABLE_BASE,
                              bus_wr && bus_sel == `CBR_SEL_VECTOR_TABLE_BASE);
  wire [31:0] sbr_n = cbr_upd({16'h0000, sbr},
                              wr_en_in && wr_sel_in == `CBR_SEL_SB,
                              bus_wr && bus_sel == `CBR_SEL_SB);
  wire [31:0] usp_n = cbr_upd({16'h0000, user_stack_pointer}, wr_en_in && c_sel_usp,
                              bus_wr && b_sel_usp);
  wire [31:0] isp_n = cbr_upd({16'h0000, interrupt_stack_pointer}, wr_en_in && c_sel_isp,
                              bus_wr && b_sel_isp);

  // sequencer advance beats an explicit core write, bus write beats both
  wire [31:0] ip_c  = cbr_merge({12'h000, ip}, wr_data_in,
                                (wr_en_in && wr_sel_in == `CBR_SEL_IP) ?
                                `CBR_BE_ALL : `CBR_BE_NONE);
  wire [19:0] ip_s  = ip_we_in ? ip_next_in : ip_c[19:0];
  wire [31:0] ip_n  = cbr_merge({12'h000, ip_s}, wb_dat_in,
                                (bus_wr && bus_sel == `CBR_SEL_IP) ?
                                wb_sel_in : `CBR_BE_NONE);

  // ----------------------------------------
  // flag update from alu
  // ----------------------------------------
  // core write to flags, lowest priority
  wire [31:0] flg_c = cbr_merge({21'h00_0000, processor_flags}, wr_data_in,
                                (wr_en_in && wr_sel_in == `CBR_SEL_FLG) ?
                                `CBR_BE_ALL : `CBR_BE_NONE);

  // zero and sign judged at the operation's size
  always @* begin
    case (alu_size_in)
      `CBR_SZ_BYTE: begin
        res_zero = (alu_result_in[7:0] == 8'h00);
        res_sign = alu_result_in[7];
      end
      `CBR_SZ_WORD: begin
        res_zero = (alu_result_in[15:0] == 16'h0000);
        res_sign = alu_result_in[15];
      end
      default: begin
        res_zero = (alu_result_in == `CBR_ZERO32);
        res_sign = alu_result_in[31];
      end
    endcase
  end

  always @* begin
    flg_alu = flg_c[10:0];
    if (alu_c_we_in)
      flg_alu[`CBR_FLG_C] = alu_carry_in;
    if (alu_zs_we_in) begin
      flg_alu[`CBR_FLG_Z] = res_zero;
      flg_alu[`CBR_FLG_S] = res_sign;
    end
    if (alu_o_we_in)
      flg_alu[`CBR_FLG_O] = alu_ovf_in;
  end

  // debug bit is stored as written; keeping it zero is up to software
  wire [31:0] flg_n = cbr_merge({21'h00_0000, flg_alu}, wb_dat_in,
                                (bus_wr && bus_sel == `CBR_SEL_FLG) ?
                                wb_sel_in : `CBR_BE_NONE);

  // ----------------------------------------
  // unbanked storage
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vtb <= `CBR_RST20;
      ip  <= `CBR_RST20;
      user_stack_pointer <= `CBR_RST16;
      interrupt_stack_pointer <= `CBR_RST16;
      sbr <= `CBR_RST16;
      processor_flags <= `CBR_FLG_RST;
    end else begin
      vtb <= vtb_n[19:0];
      ip  <= ip_n[19:0];
      user_stack_pointer <= usp_n[15:0];
      interrupt_stack_pointer <= isp_n[15:0];
      sbr <= sbr_n[15:0];
      processor_flags <= flg_n[10:0];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_out              = wb_ack;
  assign wb_dat_out              = wb_dat;
  assign rd_data_out             = rd_data;

  // ----------------------------------------
  // register outputs
  // ----------------------------------------
  assign address_register_0_out  = act_a0;
  assign address_register_1_out  = act_a1;
  assign frame_base_out          = act_fb;
  assign static_base_out         = sbr;
  assign vector_table_base_out   = vtb;
  assign instruction_pointer_out = ip;
  assign stack_pointer_out       = sp_act;
  assign processor_flags_out     = processor_flags;

endmodule // cbr_regfile

// ---- cbr_regfile_properties.sv ----
`timescale 1ns/1ps
`include "cbr_defs.vh"
module cbr_regfile_properties (
  input wire        clk_in,
  input wire        resetn_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire        wb_ack_out,
  input wire        wr_en_in,
  input wire [4:0]  rd_sel_in,
  input wire [31:0] rd_data_out,
  input wire        ip_we_in,
  input wire [19:0] ip_next_in,
  input wire        alu_c_we_in,
  input wire        alu_carry_in,
  input wire        alu_zs_we_in,
  input wire [1:0]  alu_size_in,
  input wire [31:0] alu_result_in,
  input wire        alu_o_we_in,
  input wire        alu_ovf_in,
  input wire [15:0] address_register_0_out,
  input wire [15:0] address_register_1_out,
  input wire [19:0] instruction_pointer_out,
  input wire [15:0] stack_pointer_out,
  input wire [10:0] processor_flags_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // bus write lands on the ack edge and wins over core strobes
  wire       bw = wb_ack_out & wb_we_in;
  wire [1:0] z  = alu_size_in;
  wire       zx = (z == 2'h0) ? alu_result_in[7:0] == 8'h00 :
                  (z == 2'h1) ? alu_result_in[15:0] == 16'h0000 : alu_result_in == 32'h0000_0000;
  wire       sx = (z == 2'h0) ? alu_result_in[7] : (z == 2'h1) ? alu_result_in[15] : alu_result_in[31];
  sequence take_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence answer_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  bus_answer_a: assert property (take_s |=> answer_s)
    else $error("bus ack not a single pulse after request");
  ip_load_a: assert property (ip_we_in && !bw |=> instruction_pointer_out == $past(ip_next_in))
    else $error("instruction pointer not loaded");
  carry_a: assert property (alu_c_we_in && !bw |=> processor_flags_out[0] == $past(alu_carry_in))
    else $error("carry flag wrong");
  zero_a: assert property (alu_zs_we_in && !bw |=> processor_flags_out[2] == $past(zx))
    else $error("zero flag wrong");
  sign_a: assert property (alu_zs_we_in && !bw |=> processor_flags_out[3] == $past(sx))
    else $error("sign flag wrong");
  ovf_a: assert property (alu_o_we_in && !bw |=> processor_flags_out[5] == $past(alu_ovf_in))
    else $error("overflow flag wrong");
  sp_view_a: assert property (rd_sel_in == `CBR_SEL_SP |=> rd_data_out[15:0] == $past(stack_pointer_out))
    else $error("active stack pointer view wrong");
  pair_view_a: assert property (rd_sel_in == `CBR_SEL_LONG_ADDRESS_PAIR |=>
      rd_data_out == {$past(address_register_1_out), $past(address_register_0_out)})
    else $error("address pair view wrong");
  flag_view_a: assert property (rd_sel_in == `CBR_SEL_FLG |=> rd_data_out[10:0] == $past(processor_flags_out))
    else $error("flag view wrong");
  bank_hold_a: assert property (!wr_en_in && !bw |=>
      $stable(address_register_0_out) || $changed(processor_flags_out[4]))
    else $error("banked register drifted");
endmodule // cbr_regfile_properties

// ---- cbr_alu_model.sv ----
`timescale 1ns/1ps
module cbr_alu_model (
  input  wire        clk_in,
  input  wire        go_in,
  input  wire [1:0]  size_in,
  input  wire [31:0] a_in,
  input  wire [31:0] b_in,
  output reg         we_out,
  output reg  [1:0]  size_out,
  output reg  [31:0] res_out,
  output reg         c_out,
  output reg         o_out
);
  reg [32:0] m;
  reg [32:0] s;
  integer    w;
  // no path to the debug flag, so software keeps it clear
  always @(posedge clk_in) begin
    w = (size_in == 2'h0) ? 8 : (size_in == 2'h1) ? 16 : 32;
    m = (33'h1 << w) - 33'h1;
    s = ({1'b0, a_in} & m) + ({1'b0, b_in} & m);
    we_out <= go_in;
    size_out <= size_in;
    res_out <= s[31:0];
    c_out <= s[w];
    o_out <= (a_in[w-1] == b_in[w-1]) && (s[w-1] != a_in[w-1]);
  end
endmodule // cbr_alu_model

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "cbr_defs.vh"
module testbench;
  reg         clk_in = 0, resetn_in = 0, cyc = 0, stb = 0, we = 0, wr_en = 0, ip_we = 0, go = 0;
  reg  [7:0]  adr = 0;
  reg  [3:0]  sel = 0;
  reg  [4:0]  wr_sel = 0, rd_sel = 0;
  reg  [31:0] dat = 0, wr_data = 0, a = 0, b = 0, q;
  reg  [19:0] ip_next = 0;
  reg  [1:0]  size = 0;
  wire [31:0] wb_q, rd_q, res;
  wire        ack, awe, c, o;
  wire [1:0]  asz;
  wire [15:0] a0, a1, fb, sb, sp;
  wire [19:0] vb, ip;
  wire [10:0] processor_flags;
  integer     n_fail = 0, cmp_count = 0, i, t;
  cbr_regfile u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(wb_q),
    .wb_ack_out(ack), .wr_en_in(wr_en), .wr_sel_in(wr_sel), .wr_data_in(wr_data),
    .rd_sel_in(rd_sel), .rd_data_out(rd_q), .ip_we_in(ip_we), .ip_next_in(ip_next),
    .alu_c_we_in(awe), .alu_carry_in(c), .alu_zs_we_in(awe), .alu_size_in(asz),
    .alu_result_in(res), .alu_o_we_in(awe), .alu_ovf_in(o), .address_register_0_out(a0),
    .address_register_1_out(a1), .frame_base_out(fb), .static_base_out(sb),
    .vector_table_base_out(vb), .instruction_pointer_out(ip), .stack_pointer_out(sp),
    .processor_flags_out(processor_flags));
  cbr_alu_model u_alu (.clk_in(clk_in), .go_in(go), .size_in(size), .a_in(a), .b_in(b),
    .we_out(awe), .size_out(asz), .res_out(res), .c_out(c), .o_out(o));
  initial forever #5 clk_in = ~clk_in;
  // --------
  // tasks
  // --------
  task final_report;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [8*12:1] what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // waits for ack with a bound; a lost ack counts as a mismatch
  task bus(input [5:0] idx, input w, input [3:0] s, input [31:0] d);
    begin
      @(posedge clk_in);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      dat <= d;
      t = 0;
      @(posedge clk_in);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clk_in);
        t = t + 1;
      end
      if (t == 20) n_fail = n_fail + 1;
      q = wb_q;
      cyc <= 0;
      stb <= 0;
      // let the acked write settle before outputs are looked at
      @(negedge clk_in);
    end
  endtask
  task cw(input [4:0] s, input [31:0] d);
    begin
      @(posedge clk_in);
      wr_en <= 1;
      wr_sel <= s;
      wr_data <= d;
      @(posedge clk_in);
      wr_en <= 0;
    end
  endtask
  task cr(input [4:0] s);
    begin
      @(posedge clk_in);
      rd_sel <= s;
      @(posedge clk_in);
      @(negedge clk_in);
      q = rd_q;
    end
  endtask
  task alu(input [1:0] z, input [31:0] x, input [31:0] y, input [3:0] e);
    begin
      @(posedge clk_in);
      go <= 1;
      size <= z;
      a <= x;
      b <= y;
      @(posedge clk_in);
      go <= 0;
      @(posedge clk_in);
      @(negedge clk_in);
      chk({28'h000_0000, processor_flags[5], processor_flags[3], processor_flags[2], processor_flags[0]}, {28'h000_0000, e}, "alu flags");
    end
  endtask
  initial begin
    repeat (4000) @(posedge clk_in);
    n_fail = n_fail + 1;
    final_report;
  end
  // --------
  // tests
  // --------
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1;
    for (i = 0; i < 13; i = i + 1) begin
      bus(i[5:0], 0, 4'hf, 0);
      chk(q, 0, "reset value");
    end
    bus(6'h20, 1, 4'hf, 32'hffff_ffff);
    bus(6'h20, 0, 4'hf, 0);
    chk(q, 0, "unmapped");
    $display("test reset done");
    for (i = 0; i < 12; i = i + 1) begin
      bus(i[5:0], 1, 4'hf, 32'hffff_ffff);
      bus(i[5:0], 0, 4'hf, 0);
      chk(q, (i == 7 || i == 8) ? 32'h000f_ffff : 32'h0000_ffff, "width");
    end
    chk({12'h000, vb}, 32'h000f_ffff, "vector base");
    chk({fb, sb}, 32'hffff_ffff, "bases");
    bus(6'h0c, 1, 4'hf, 32'h0000_07fd);
    bus(6'h0c, 0, 4'hf, 0);
    chk(q, 32'h0000_07fd, "flags");
    bus(6'h00, 0, 4'hf, 0);
    chk(q, 0, "bank1 data0");
    bus(6'h00, 1, 4'hf, 32'h0000_1234);
    chk({16'h0000, a0}, 0, "bank1 addr0");
    bus(6'h0c, 1, 4'hf, 0);
    bus(6'h00, 0, 4'hf, 0);
    chk(q, 32'h0000_ffff, "bank0 data0");
    bus(6'h0c, 1, 4'hf, 32'h0000_0010);
    bus(6'h00, 0, 4'hf, 0);
    chk(q, 32'h0000_1234, "bank1 data0");
    bus(6'h0c, 1, 4'hf, 0);
    $display("test bank done");
    cw(`CBR_SEL_R0L, 32'h0000_005a);
    cw(`CBR_SEL_R0H, 32'h0000_00a5);
    cr(`CBR_SEL_R0);
    chk({16'h0000, q[15:0]}, 32'h0000_a55a, "byte data0");
    bus(6'h10, 1, 4'h1, 32'h0000_003c);
    cr(`CBR_SEL_R1);
    chk({16'h0000, q[15:0]}, 32'h0000_3cff, "byte data1");
    $display("test bytes done");
    cw(`CBR_SEL_LONG_DATA_PAIR_LOW, 32'h1111_2222);
    cw(`CBR_SEL_LONG_DATA_PAIR_HIGH, 32'h3333_4444);
    cw(`CBR_SEL_LONG_ADDRESS_PAIR, 32'h5555_6666);
    cr(`CBR_SEL_LONG_DATA_PAIR_LOW);
    chk(q, 32'h1111_2222, "pair 2:0");
    cr(`CBR_SEL_LONG_DATA_PAIR_HIGH);
    chk(q, 32'h3333_4444, "pair 3:1");
    cr(`CBR_SEL_LONG_ADDRESS_PAIR);
    chk({a1, a0}, 32'h5555_6666, "addr pair");
    $display("test pairs done");
    bus(6'h09, 1, 4'hf, 32'h0000_0100);
    bus(6'h0a, 1, 4'hf, 32'h0000_0200);
    chk({16'h0000, sp}, 32'h0000_0100, "user sp");
    bus(6'h0c, 1, 4'hf, 32'h0000_0080);
    chk({16'h0000, sp}, 32'h0000_0200, "int sp");
    cw(`CBR_SEL_SP, 32'h0000_0abc);
    cr(`CBR_SEL_SP);
    chk({16'h0000, q[15:0]}, 32'h0000_0abc, "active sp");
    bus(6'h09, 0, 4'hf, 0);
    chk(q, 32'h0000_0100, "user sp kept");
    $display("test stack done");
    alu(2'h0, 32'h0000_0080, 32'h0000_0080, 4'b1011);
    alu(2'h1, 32'h0000_7fff, 32'h0000_0001, 4'b1100);
    alu(2'h2, 32'hffff_ffff, 32'h0000_0001, 4'b0011);
    alu(2'h1, 32'h0000_0001, 32'h0000_0002, 4'b0000);
    $display("test alu done");
    @(posedge clk_in);
    ip_we <= 1;
    ip_next <= 20'ha_bcde;
    @(posedge clk_in);
    ip_we <= 0;
    cr(`CBR_SEL_IP);
    chk({12'h000, ip}, 32'h000a_bcde, "ip");
    cr(`CBR_SEL_FLG);
    chk({21'h00_0000, q[10:0]}, 32'h0000_0080, "flag view");
    $display("test ip done");
    final_report;
  end
endmodule // testbench
bind cbr_regfile cbr_regfile_properties u_chk (.clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_ack_out, .wr_en_in, .rd_sel_in, .rd_data_out, .ip_we_in, .ip_next_in,
  .alu_c_we_in, .alu_carry_in, .alu_zs_we_in, .alu_size_in, .alu_result_in, .alu_o_we_in,
  .alu_ovf_in, .address_register_0_out, .address_register_1_out, .instruction_pointer_out,
  .stack_pointer_out, .processor_flags_out);
